// ===== logic/gwc_pkg.sv
// Package with constants and types of the guest watchpoint controller
package gwc_pkg;
   // Sizes
   localparam int unsigned NUM_PAIRS   = 4;
   localparam int unsigned IDX_W       = 2;
   localparam int unsigned ADDRESS_SPACE_ID_W      = 8;
   localparam int unsigned RST_STAGES  = 2;

   // Register offsets, byte addresses of 32-bit words
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_STATUS    = 8'h04;
   localparam logic [7:0] OFF_XLATE     = 8'h08;
   localparam logic [7:0] OFF_GDATA     = 8'h0c;
   localparam logic [7:0] OFF_PAIR_BASE = 8'h10;
   localparam logic [7:0] OFF_PAIR_END  = 8'h30;

   // Control register fields
   localparam int unsigned CTRL_GFLAG    = 0;
   localparam int unsigned CTRL_GFLAG_RW = 1;
   localparam int unsigned CTRL_GPA_IMPL = 2;
   localparam int unsigned CTRL_SUBSET   = 3;
   localparam int unsigned CTRL_POLICY   = 4;
   localparam int unsigned CTRL_CFG_DONE = 6;
   localparam int unsigned CTRL_W        = 7;
   localparam logic [6:0]  CTRL_RESET    = 7'h00;

   // Status register fields
   localparam int unsigned STAT_RHIT   = 0;
   localparam int unsigned STAT_GHIT   = 4;
   localparam int unsigned STAT_GACT   = 8;
   localparam int unsigned STAT_XDONE  = 9;

   // Watch high word fields
   localparam int unsigned HI_WM    = 0;
   localparam int unsigned HI_MASK  = 3;
   localparam int unsigned HI_ADDRESS_SPACE_ID  = 16;
   localparam int unsigned HI_G     = 30;
   localparam int unsigned HI_M     = 31;
   localparam logic [31:0] HI_RESET = 32'h0000_0000;
   localparam logic [31:0] LO_RESET = 32'h0000_0000;

   // Owner mode field encodings
   localparam logic [1:0] WM_ROOT_RVA  = 2'h0;
   localparam logic [1:0] WM_ROOT_GPA  = 2'h1;
   localparam logic [1:0] WM_GUEST_GVA = 2'h2;
   localparam logic [1:0] WM_RESERVED  = 2'h3;

   // Handling of guest accesses when no guest pairs exist
   localparam logic [1:0] POL_NOP  = 2'h0;
   localparam logic [1:0] POL_TRAP = 2'h1;
   localparam logic [1:0] POL_ZERO = 2'h2;

   // Guest translation buffer operations started by root
   typedef enum logic [1:0] {
      XL_PROBE, XL_READ, XL_WRITE_INDEXED, XL_WRITE_RANDOM
   } gwc_xlate_op_type;

   // Memory access offered for watch comparison
   typedef struct packed {
      logic        valid;
      logic [2:0]  kind;   // Fetch, load, store
      logic [31:0] vaddr;
      logic [31:0] guest_physical_address;
   } gwc_access_type;

   // Guest move to or from a watch register
   typedef struct packed {
      logic             req;
      logic             wr;
      logic             hi;
      logic [IDX_W-1:0] idx;
      logic [31:0]      wdata;
   } gwc_gacc_type;

   // Processor mode bits
   typedef struct packed {
      logic guest_mode_bit;
      logic exception_level_bit;
      logic error_level_bit;
      logic debug_mode_bit;
   } gwc_mode_type;
endpackage : gwc_pkg

// ===== logic/gwc_top.sv
// Guest watchpoint control and debug access logic
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module gwc_top (
   // Clock, reset and enable
   input  wire logic                       REF_CLK,
   input  wire logic                       RST_N,
   input  wire logic                       CE,
   // Register port
   input  wire logic [7:0]                 ADDR,
   input  wire logic [31:0]                WDATA,
   input  wire logic                       WR_EN,
   input  wire logic                       RD_EN,
   output logic      [31:0]                RDATA,
   // Processor mode and identifiers
   input  wire gwc_pkg::gwc_mode_type      CPU_MODE,
   input  wire logic [7:0]                 ROOT_ADDRESS_SPACE_ID,
   input  wire logic [7:0]                 GUEST_ADDRESS_SPACE_ID,
   // Access to be watched
   input  wire gwc_pkg::gwc_access_type    ACCESS,
   // Guest watch register access
   input  wire gwc_pkg::gwc_gacc_type      GUEST_REQ,
   output logic      [31:0]                GUEST_RDATA,
   output logic                            GUEST_TRAP,
   output logic                            GUEST_WATCH_PRESENT,
   // Watch exceptions
   output logic                            ROOT_WATCH_EXC,
   output logic                            GUEST_WATCH_EXC,
   output logic      [3:0]                 WATCH_HIT_PAIR,
   // Hardware breakpoints
   input  wire logic                       BKPT_HIT,
   input  wire logic                       BKPT_SYNC,
   output logic                            DBG_EXC_SYNC,
   output logic                            DBG_EXC_ASYNC,
   // Guest control state and translation buffer
   output logic                            GCTL_WR,
   output logic      [31:0]                GCTL_WDATA,
   output logic                            GCTL_RD,
   input  wire logic [31:0]                GCTL_RDATA,
   output logic                            XLATE_REQ,
   output gwc_pkg::gwc_xlate_op_type       XLATE_OP,
   input  wire logic                       XLATE_DONE
);
   localparam int unsigned N = gwc_pkg::NUM_PAIRS;

   logic [gwc_pkg::RST_STAGES-1:0] rst_sync_reg;
   logic                            rst_n;
   logic [6:0]                      ctrl_reg;
   logic [31:0]                     lo_reg [N];
   logic [31:0]                     hi_reg [N];
   logic [2*N-1:0]                  wm_vec;
   logic [N-1:0]                    rhit_c;
   logic [N-1:0]                    ghit_c;
   logic [N-1:0]                    rhit_sticky_reg;
   logic [N-1:0]                    ghit_sticky_reg;
   logic                            xdone_reg;
   logic                            guest_active;
   logic                            gflag;
   logic                            pair_sel;
   logic [7:0]                      pair_off;
   logic [gwc_pkg::IDX_W-1:0]       bus_idx;
   logic                            bus_hi;
   logic                            g_owned;
   logic                            g_trap_c;
   logic                            g_ok;
   logic                            g_more;
   logic [31:0]                     rd_mux;
   logic [31:0]                     status_word;

   // Reset release through two flip-flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_sync_reg <= '0;
      end else if (CE) begin
         rst_sync_reg <= {rst_sync_reg[gwc_pkg::RST_STAGES-2:0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[gwc_pkg::RST_STAGES-1];

   // Guest matching window excludes root intervention
   assign guest_active = CPU_MODE.guest_mode_bit
                       & ~CPU_MODE.exception_level_bit
                       & ~CPU_MODE.error_level_bit
                       & ~CPU_MODE.debug_mode_bit;
   assign gflag = ctrl_reg[gwc_pkg::CTRL_GFLAG];
   assign GUEST_WATCH_PRESENT = gflag;

   // Register port decode
   assign pair_off = ADDR - gwc_pkg::OFF_PAIR_BASE;
   assign pair_sel = (ADDR >= gwc_pkg::OFF_PAIR_BASE)
                   && (ADDR < gwc_pkg::OFF_PAIR_END)
                   && (ADDR[1:0] == 2'h0);
   assign bus_idx  = pair_off[4:3];
   assign bus_hi   = pair_off[2];

   // Owner field filter applied to root writes
   function automatic logic [1:0] fold_wm(input logic [1:0] wm,
                                          input logic       gpa_impl);
      logic [1:0] res;
      res = wm;
      if (wm == gwc_pkg::WM_RESERVED) begin
         res = gwc_pkg::WM_GUEST_GVA;
      end else if (wm == gwc_pkg::WM_ROOT_GPA && !gpa_impl) begin
         res = gwc_pkg::WM_ROOT_RVA;
      end
      return res;
   endfunction : fold_wm

   // Address, mask, kind and identifier comparison of one pair
   function automatic logic pair_match(input logic [31:0] lo,
                                       input logic [31:0] hi,
                                       input logic [31:0] addr,
                                       input logic [2:0]  kind,
                                       input logic [7:0]  address_space_id);
      logic [31:0] diff;
      logic        id_ok;
      diff  = (addr ^ lo) & ~{20'h0_0000, hi[11:3], 3'h7};
      id_ok = hi[gwc_pkg::HI_G]
            || (hi[gwc_pkg::HI_ADDRESS_SPACE_ID +: gwc_pkg::ADDRESS_SPACE_ID_W] == address_space_id);
      return (diff == 32'h0) && ((lo[2:0] & kind) != 3'h0) && id_ok;
   endfunction : pair_match

   // Guest access checks on the addressed pair
   assign g_owned = wm_vec[2*GUEST_REQ.idx + 1];
   assign g_more  = (GUEST_REQ.idx == gwc_pkg::IDX_W'(N - 1)) ? 1'b0
                  : wm_vec[2*GUEST_REQ.idx + 3];
   always_comb begin
      g_trap_c = 1'b0;
      if (GUEST_REQ.req) begin
         if (!gflag) begin
            g_trap_c = (ctrl_reg[gwc_pkg::CTRL_POLICY +: 2]
                        == gwc_pkg::POL_TRAP);
         end else if (ctrl_reg[gwc_pkg::CTRL_SUBSET]
                      && !ctrl_reg[gwc_pkg::CTRL_CFG_DONE]) begin
            g_trap_c = 1'b1;
         end else begin
            g_trap_c = !g_owned;
         end
      end
   end
   assign g_ok = GUEST_REQ.req && gflag && !g_trap_c;

   // Per pair storage and matching
   for (genvar i = 0; i < N; i++) begin : g_pair
      logic bus_wr_lo;
      logic bus_wr_hi;
      logic g_wr;
      assign bus_wr_lo = WR_EN && pair_sel && bus_idx == i && !bus_hi;
      assign bus_wr_hi = WR_EN && pair_sel && bus_idx == i && bus_hi;
      assign g_wr = g_ok && GUEST_REQ.wr
                  && GUEST_REQ.idx == gwc_pkg::IDX_W'(i);
      assign wm_vec[2*i +: 2] = hi_reg[i][1:0];

      // Root writes win over guest writes and never trap
      always_ff @(posedge REF_CLK or negedge rst_n) begin
         if (!rst_n) begin
            lo_reg[i] <= gwc_pkg::LO_RESET;
            hi_reg[i] <= gwc_pkg::HI_RESET;
         end else if (CE) begin
            if (bus_wr_lo) begin
               lo_reg[i] <= WDATA;
            end else if (g_wr && !GUEST_REQ.hi) begin
               lo_reg[i] <= GUEST_REQ.wdata;
            end
            if (bus_wr_hi) begin
               hi_reg[i] <= {1'b0, WDATA[30:2],
                  fold_wm(WDATA[1:0], ctrl_reg[gwc_pkg::CTRL_GPA_IMPL])};
            end else if (g_wr && GUEST_REQ.hi) begin
               hi_reg[i] <= {1'b0, GUEST_REQ.wdata[30:2],
                             hi_reg[i][1:0]};
            end
         end
      end

      // Root and guest pairs compare independently
      always_comb begin
         rhit_c[i] = 1'b0;
         ghit_c[i] = 1'b0;
         if (ACCESS.valid) begin
            if (!gflag || !hi_reg[i][1]) begin
               if (hi_reg[i][0]) begin
                  rhit_c[i] = guest_active && pair_match(lo_reg[i],
                     hi_reg[i], ACCESS.guest_physical_address, ACCESS.kind, GUEST_ADDRESS_SPACE_ID);
               end else begin
                  rhit_c[i] = !guest_active && pair_match(lo_reg[i],
                     hi_reg[i], ACCESS.vaddr, ACCESS.kind, ROOT_ADDRESS_SPACE_ID);
               end
            end else if (hi_reg[i][1:0] == gwc_pkg::WM_GUEST_GVA) begin
               ghit_c[i] = guest_active && pair_match(lo_reg[i],
                  hi_reg[i], ACCESS.vaddr, ACCESS.kind, GUEST_ADDRESS_SPACE_ID);
            end
         end
      end
   end

   // Control register; the guest flag moves only while root may write it
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= gwc_pkg::CTRL_RESET;
      end else if (CE && WR_EN && ADDR == gwc_pkg::OFF_CTRL) begin
         ctrl_reg[6:1] <= WDATA[6:1];
         if (ctrl_reg[gwc_pkg::CTRL_GFLAG_RW]) begin
            ctrl_reg[gwc_pkg::CTRL_GFLAG] <= WDATA[0];
         end
      end
   end

   // Watch exceptions go to the mode that owns the pair
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ROOT_WATCH_EXC  <= 1'b0;
         GUEST_WATCH_EXC <= 1'b0;
         WATCH_HIT_PAIR  <= 4'h0;
      end else if (CE) begin
         ROOT_WATCH_EXC  <= |rhit_c;
         GUEST_WATCH_EXC <= |ghit_c;
         WATCH_HIT_PAIR  <= rhit_c | ghit_c;
      end
   end

   // Sticky hit flags, cleared by writing ones, a new hit wins
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rhit_sticky_reg <= '0;
         ghit_sticky_reg <= '0;
         xdone_reg       <= 1'b0;
      end else if (CE) begin
         if (WR_EN && ADDR == gwc_pkg::OFF_STATUS) begin
            rhit_sticky_reg <= (rhit_sticky_reg & ~WDATA[3:0]) | rhit_c;
            ghit_sticky_reg <= (ghit_sticky_reg & ~WDATA[7:4]) | ghit_c;
         end else begin
            rhit_sticky_reg <= rhit_sticky_reg | rhit_c;
            ghit_sticky_reg <= ghit_sticky_reg | ghit_c;
         end
         if (XLATE_DONE) begin
            xdone_reg <= 1'b1;
         end else if (WR_EN && ADDR == gwc_pkg::OFF_XLATE) begin
            xdone_reg <= 1'b0;
         end
      end
   end

   // Guest moves answer one cycle later; a trap stands one cycle for each cycle of trapping request
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         GUEST_TRAP  <= 1'b0;
         GUEST_RDATA <= 32'h0000_0000;
      end else if (CE) begin
         GUEST_TRAP  <= g_trap_c;
         GUEST_RDATA <= 32'h0000_0000;
         if (g_ok && !GUEST_REQ.wr) begin
            if (GUEST_REQ.hi) begin
               GUEST_RDATA <= {g_more, hi_reg[GUEST_REQ.idx][30:2],
                               2'h0};
            end else begin
               GUEST_RDATA <= lo_reg[GUEST_REQ.idx];
            end
         end
      end
   end

   // Breakpoints belong to root and fire in any context
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         DBG_EXC_SYNC  <= 1'b0;
         DBG_EXC_ASYNC <= 1'b0;
      end else if (CE) begin
         DBG_EXC_SYNC  <= BKPT_HIT && BKPT_SYNC;
         DBG_EXC_ASYNC <= BKPT_HIT && !BKPT_SYNC;
      end
   end

   // Guest control moves and guest translation operations
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         GCTL_WR    <= 1'b0;
         GCTL_RD    <= 1'b0;
         GCTL_WDATA <= 32'h0000_0000;
         XLATE_REQ  <= 1'b0;
         XLATE_OP   <= gwc_pkg::XL_PROBE;
      end else if (CE) begin
         GCTL_WR   <= WR_EN && ADDR == gwc_pkg::OFF_GDATA;
         GCTL_RD   <= RD_EN && ADDR == gwc_pkg::OFF_GDATA;
         XLATE_REQ <= WR_EN && ADDR == gwc_pkg::OFF_XLATE;
         if (WR_EN && ADDR == gwc_pkg::OFF_GDATA) begin
            GCTL_WDATA <= WDATA;
         end
         if (WR_EN && ADDR == gwc_pkg::OFF_XLATE) begin
            XLATE_OP <= gwc_pkg::gwc_xlate_op_type'(WDATA[1:0]);
         end
      end
   end

   // Read multiplexer; unmapped words read as zero
   assign status_word = {22'h0, xdone_reg, guest_active,
                         ghit_sticky_reg, rhit_sticky_reg};
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (pair_sel) begin
         rd_mux = bus_hi ? hi_reg[bus_idx] : lo_reg[bus_idx];
      end else begin
         case (ADDR)
            gwc_pkg::OFF_CTRL:   rd_mux = {25'h0, ctrl_reg};
            gwc_pkg::OFF_STATUS: rd_mux = status_word;
            gwc_pkg::OFF_XLATE:  rd_mux = {30'h0, XLATE_OP};
            gwc_pkg::OFF_GDATA:  rd_mux = GCTL_RDATA;
            default:             rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 32'h0000_0000;
      end else if (CE) begin
         RDATA <= RD_EN ? rd_mux : 32'h0000_0000;
      end
   end

   // Helper for checks on the pair last written by root
   logic [gwc_pkg::IDX_W-1:0] last_idx_reg;
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         last_idx_reg <= '0;
      end else if (CE && WR_EN && pair_sel) begin
         last_idx_reg <= bus_idx;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!rst_n);

   sequence s_guest_to_root_pair;
      CE && GUEST_REQ.req && gflag && !g_owned
         && !ctrl_reg[gwc_pkg::CTRL_SUBSET];
   endsequence
   sequence s_trap_pulse;
      GUEST_TRAP ##1 (!GUEST_TRAP || $past(g_trap_c));
   endsequence

   a_root_never_traps: assert property (
      CE && !GUEST_REQ.req |=> !GUEST_TRAP)
      else $error("trap raised without a guest access");
   a_root_pair_trap: assert property (
      s_guest_to_root_pair |=> s_trap_pulse)
      else $error("guest access to root pair did not trap");
   a_subset_first_trap: assert property (
      CE && GUEST_REQ.req && gflag && ctrl_reg[gwc_pkg::CTRL_SUBSET]
         && !ctrl_reg[gwc_pkg::CTRL_CFG_DONE] |=> GUEST_TRAP)
      else $error("first guest access in subset mode did not trap");
   a_guest_wm_kept: assert property (
      CE && g_ok && GUEST_REQ.wr && GUEST_REQ.hi && !(WR_EN && pair_sel)
         |=> wm_vec == $past(wm_vec))
      else $error("guest write changed owner field");
   a_guest_wm_reads_zero: assert property (
      CE && g_ok && !GUEST_REQ.wr && GUEST_REQ.hi
         |=> GUEST_RDATA[1:0] == 2'h0)
      else $error("guest read returned owner field bits");
   a_gpa_fold: assert property (
      CE && WR_EN && pair_sel && bus_hi && WDATA[1:0] == 2'h1
         && !ctrl_reg[gwc_pkg::CTRL_GPA_IMPL]
         |=> wm_vec[2*last_idx_reg +: 2] == gwc_pkg::WM_ROOT_RVA)
      else $error("owner value 1 stored without GUEST_PHYSICAL_ADDRESS support");
   a_reserved_fold: assert property (
      CE && WR_EN && pair_sel && bus_hi && WDATA[1:0] == 2'h3
         |=> wm_vec[2*last_idx_reg +: 2] == gwc_pkg::WM_GUEST_GVA)
      else $error("owner value 3 not folded to 2");
   a_guest_match_gate: assert property (
      GUEST_WATCH_EXC && $past(CE) |-> $past(guest_active) && $past(gflag))
      else $error("guest watch outside plain guest mode");
   a_bkpt_sync_debug: assert property (
      CE && BKPT_HIT && BKPT_SYNC |=> DBG_EXC_SYNC && !DBG_EXC_ASYNC)
      else $error("synchronous breakpoint not reported");
   a_no_guest_zero: assert property (
      CE && GUEST_REQ.req && !gflag |=> GUEST_RDATA == 32'h0000_0000)
      else $error("guest read with no guest pairs returned data");
endmodule : gwc_top

// ===== testbench/tb_top.sv
// Self-checking testbench of the guest watchpoint controller
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
   logic                      ref_clk, rst_n, wr_en, rd_en, bkpt_hit;
   logic                      bkpt_sync, xlate_done, guest_trap, gw_present;
   logic                      root_exc, guest_exc, dbg_sync, dbg_async;
   logic                      gctl_wr, gctl_rd, xlate_req;
   logic [7:0]                addr, guest_address_space_id;
   logic [31:0]               wdata, rdata, guest_rdata, gctl_wdata;
   logic [31:0]               gctl_rdata;
   logic [3:0]                hit_pair;
   gwc_pkg::gwc_mode_type     cpu_mode;
   gwc_pkg::gwc_access_type   access;
   gwc_pkg::gwc_gacc_type     gacc;
   gwc_pkg::gwc_xlate_op_type xlate_op;
   int                        n_mismatch, num_checks, cycles;

   // Device under test; enable and root identifier held constant
   gwc_top u_gwc_top (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'b1),
      .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
      .RDATA(rdata), .CPU_MODE(cpu_mode), .ROOT_ADDRESS_SPACE_ID(8'h00),
      .GUEST_ADDRESS_SPACE_ID(guest_address_space_id), .ACCESS(access), .GUEST_REQ(gacc),
      .GUEST_RDATA(guest_rdata), .GUEST_TRAP(guest_trap),
      .GUEST_WATCH_PRESENT(gw_present), .ROOT_WATCH_EXC(root_exc),
      .GUEST_WATCH_EXC(guest_exc), .WATCH_HIT_PAIR(hit_pair),
      .BKPT_HIT(bkpt_hit), .BKPT_SYNC(bkpt_sync), .DBG_EXC_SYNC(dbg_sync),
      .DBG_EXC_ASYNC(dbg_async), .GCTL_WR(gctl_wr), .GCTL_WDATA(gctl_wdata),
      .GCTL_RD(gctl_rd), .GCTL_RDATA(gctl_rdata), .XLATE_REQ(xlate_req),
      .XLATE_OP(xlate_op), .XLATE_DONE(xlate_done));

   // Clock of 100 ns period
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Cuts a hung run short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // Verdict and end of run
   task automatic print_verdict();
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // One-cycle register write; the write lands at the closing edge
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask : reg_wr

   // One-cycle register read, data compared in the following cycle
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : reg_rd

   // Guest move to or from a watch register, trap and data compared
   task automatic gx(input logic w, h, input logic [1:0] i,
                     input logic [31:0] d, input logic t, input logic [31:0] e);
      @(posedge ref_clk);
      gacc <= '{1'b1, w, h, i, d};
      @(posedge ref_clk);
      gacc.req <= 1'b0;
      #1;
      `CHK(guest_trap, t)
      `CHK(guest_rdata, e)
   endtask : gx

   // One load access offered for watching, both exceptions compared
   task automatic ax(input logic [31:0] va, gp, input logic r, g);
      @(posedge ref_clk);
      access <= '{1'b1, 3'h2, va, gp};
      @(posedge ref_clk);
      access.valid <= 1'b0;
      #1;
      `CHK(root_exc, r)
      `CHK(guest_exc, g)
   endtask : ax

   // Reset state, unmapped space and owner field folding
   task automatic t_regs();
      reg_rd(8'h00, 32'h0); reg_rd(8'h14, 32'h0); reg_rd(8'h40, 32'h0);
      `CHK(gw_present, 1'b0)
      reg_wr(8'h14, 32'h1); reg_rd(8'h14, 32'h0);
      reg_wr(8'h14, 32'h3); reg_rd(8'h14, 32'h2);
      reg_wr(8'h00, 32'h4); reg_wr(8'h14, 32'h1);
      reg_rd(8'h14, 32'h1);
   endtask : t_regs

   // Root address watch, virtual and guest physical with identifier
   task automatic t_root();
      reg_wr(8'h10, 32'h1002); reg_wr(8'h14, 32'h0);
      ax(32'h1004, 32'h0, 1'b1, 1'b0);
      `CHK(hit_pair, 4'h1)
      ax(32'h2000, 32'h0, 1'b0, 1'b0);
      reg_wr(8'h14, 32'h0005_0001);
      cpu_mode <= 4'h8; guest_address_space_id <= 8'h05;
      ax(32'h0, 32'h1000, 1'b1, 1'b0);
      guest_address_space_id <= 8'h06;
      ax(32'h0, 32'h1000, 1'b0, 1'b0);
      reg_wr(8'h14, 32'h4005_0001);
      ax(32'h0, 32'h1000, 1'b1, 1'b0);
   endtask : t_root

   // Shared pairs: traps, hidden owner field, chaining bit, guest watch
   task automatic t_guest();
      cpu_mode <= 4'h0;
      reg_wr(8'h00, 32'h6); reg_wr(8'h00, 32'h7);
      `CHK(gw_present, 1'b1)
      reg_wr(8'h14, 32'h0);
      gx(1'b0, 1'b1, 2'h0, 32'h0, 1'b1, 32'h0);
      reg_wr(8'h14, 32'h2); reg_wr(8'h1c, 32'h2);
      reg_wr(8'h24, 32'h2); reg_wr(8'h2c, 32'h2);
      `CHK(guest_trap, 1'b0)
      gx(1'b0, 1'b1, 2'h0, 32'h0, 1'b0, 32'h8000_0000);
      gx(1'b0, 1'b1, 2'h3, 32'h0, 1'b0, 32'h0);
      gx(1'b1, 1'b1, 2'h0, 32'h8, 1'b0, 32'h0);
      reg_rd(8'h14, 32'ha);
      cpu_mode <= 4'h8; guest_address_space_id <= 8'h00; // Allotment held
      ax(32'h1000, 32'h0, 1'b0, 1'b1);
      cpu_mode <= 4'hc;
      ax(32'h1000, 32'h0, 1'b0, 1'b0);
      cpu_mode <= 4'h9;
      ax(32'h1000, 32'h0, 1'b0, 1'b0);
      cpu_mode <= 4'h0;
      reg_wr(8'h00, 32'h0f);
      gx(1'b0, 1'b0, 2'h0, 32'h0, 1'b1, 32'h0);
      reg_wr(8'h00, 32'h4f);
      gx(1'b0, 1'b0, 2'h0, 32'h0, 1'b0, 32'h1002);
   endtask : t_guest

   // No guest pairs: trap or zero policy, pairs revert to root
   task automatic t_noguest();
      reg_wr(8'h00, 32'h16);
      gx(1'b0, 1'b0, 2'h0, 32'h0, 1'b1, 32'h0);
      reg_wr(8'h00, 32'h26);
      gx(1'b0, 1'b0, 2'h0, 32'h0, 1'b0, 32'h0);
      ax(32'h1000, 32'h0, 1'b1, 1'b0);
   endtask : t_noguest

   // Breakpoints in guest mode, guest control moves, buffer operations
   task automatic t_debug();
      cpu_mode <= 4'h8;
      for (int s = 0; s < 2; s++) begin
         @(posedge ref_clk);
         bkpt_hit <= 1'b1; bkpt_sync <= s[0];
         @(posedge ref_clk);
         bkpt_hit <= 1'b0;
         #1;
         `CHK({dbg_sync, dbg_async}, {s[0], ~s[0]})
      end
      reg_wr(8'h0c, 32'h1234_5678);
      `CHK({gctl_wr, gctl_wdata}, {1'b1, 32'h1234_5678})
      reg_rd(8'h0c, 32'hcafe_0001);
      `CHK(gctl_rd, 1'b1)
      for (int op = 0; op < 4; op++) begin
         reg_wr(8'h08, op);
         `CHK({xlate_req, xlate_op}, {1'b1, op[1:0]})
      end
      reg_rd(8'h08, 32'h3);
      cpu_mode <= 4'h0; xlate_done <= 1'b1;
      @(posedge ref_clk);
      xlate_done <= 1'b0;
      reg_wr(8'h04, 32'hff);
      reg_rd(8'h04, 32'h200);
   endtask : t_debug

   // Main sequence
   initial begin
      rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00;
      wdata = 32'h0; cpu_mode = 4'h0; guest_address_space_id = 8'h00;
      access = '0; gacc = '0; bkpt_hit = 1'b0; bkpt_sync = 1'b0;
      xlate_done = 1'b0; gctl_rdata = 32'hcafe_0001;
      n_mismatch = 0; num_checks = 0; cycles = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs();
      t_root();
      t_guest();
      t_noguest();
      t_debug();
      print_verdict();
   end
endmodule : tb_top
